// ### port_strap_regs.svh
// Purpose: Offsets, field positions, reset values and codes for the strap and LED block
// Assumes: AXI4-Lite register access with 32-bit data
// Notes: Included by the block and by the bench
// How it works
// - A low indicator strap at reset enables per-port indicator LEDs and reports that support.
// - A high indicator strap at reset leaves the LEDs unused and reports no indicator support.
// - The indicator strap pin also serves as target address bit 3 while an SMBus host is attached.
// - Each port's removable strap high marks it removable, low marks it non-removable.
// - After reset each removable strap pin drives that port's active-low amber LED.
// - Each port-used strap high keeps the port enabled, low makes the port inactive.
// - After reset each port-used strap pin drives that port's active-low green LED.
// - Control outputs drive the downstream port power switches.
// - Green shows an enabled port, amber an over-current in the state set by power switching.
`ifndef PORT_STRAP_REGS_SVH
`define PORT_STRAP_REGS_SVH

`define ADDR_W 8
`define STATUS_OFF 8'h00
`define CTRL_OFF 8'h04
// Status fields
`define ST_REMOVABLE_LSB 0
`define ST_USED_LSB 4
`define ST_IND_EN_BIT 8
`define ST_LOADED_BIT 9
// Control fields
`define CT_PWR_SW_BIT 0
`define CT_PWR_ON_LSB 4
`define CTRL_RESET 8'h00
// Strap defaults (internal pull-ups)
`define STRAP_PORT_RESET 4'hf
// AXI responses
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// ### port_strap_pkg.sv
// Purpose: Types for the strap and LED block
// Assumes: Nothing beyond the constants header
// Notes: Port state groups follow the indicator colour table
package port_strap_pkg;
   // Gray coded along sample -> led
   typedef enum logic {
      st_sample = 1'b0,
      st_led = 1'b1
   } phase_t;

   typedef enum logic [1:0] {
      ps_powered_off = 2'b00,
      ps_disconnected = 2'b01,
      ps_suspended = 2'b10,
      ps_enabled = 2'b11
   } port_state_t;
endpackage : port_strap_pkg

// ### port_strap_and_indicator_leds.sv
// Purpose: Capture port straps after reset, then drive the shared pins as indicator LEDs
// Assumes: Pins synchronous to aclk; ce freezes all state
// Notes: Descriptor outputs feed the hub's descriptor logic
`timescale 1ns/10ps
`include "port_strap_regs.svh"
module port_strap_and_indicator_leds
   import port_strap_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic [`ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [`ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic indicator_strap_addr_bit3,
   input wire logic smbus_host_attached,
   output logic target_address_bit3,
   input wire logic [3:0] amber_led_removable_in,
   output logic [3:0] amber_led_removable_out,
   output logic [3:0] amber_led_removable_oe,
   input wire logic [3:0] green_led_port_active_in,
   output logic [3:0] green_led_port_active_out,
   output logic [3:0] green_led_port_active_oe,
   input wire logic [3:0] overcurrent_in_n,
   input wire logic [7:0] port_state,
   output logic [3:0] port_power_en_n,
   output logic [3:0] port_removable,
   output logic [3:0] port_used,
   output logic indicator_support
);

   // ----------------------------------------------------------------
   // Colour decode
   // ----------------------------------------------------------------
   function automatic logic green_on(input logic [1:0] st);
      green_on = (st == ps_enabled);
   endfunction : green_on

   function automatic logic amber_on(input logic [1:0] st, input logic oc_n, input logic sw);
      amber_on = !oc_n && (sw ? (st == ps_powered_off) : (st == ps_disconnected));
   endfunction : amber_on

   // ----------------------------------------------------------------
   // Strap capture and phase
   // ----------------------------------------------------------------
   phase_t phase_reg;
   logic [3:0] removable_reg;
   logic [3:0] used_reg;
   logic ind_en_reg;
   logic [7:0] ctrl_reg;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         phase_reg <= st_sample;
         removable_reg <= `STRAP_PORT_RESET;
         used_reg <= `STRAP_PORT_RESET;
         ind_en_reg <= 1'b0;
      end else if (ce && phase_reg == st_sample) begin
         removable_reg <= amber_led_removable_in;
         used_reg <= green_led_port_active_in;
         ind_en_reg <= !indicator_strap_addr_bit3;
         phase_reg <= st_led;
      end
   end

   assign port_removable = removable_reg;
   assign port_used = used_reg;
   assign indicator_support = ind_en_reg;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         target_address_bit3 <= 1'b0;
      end else if (ce) begin
         target_address_bit3 <= smbus_host_attached & indicator_strap_addr_bit3;
      end
   end

   // ----------------------------------------------------------------
   // LED pins and power switches
   // ----------------------------------------------------------------
   wire pwr_sw = ctrl_reg[`CT_PWR_SW_BIT];
   wire leds_live = (phase_reg == st_led) && ind_en_reg;

   genvar p;
   generate
      for (p = 0; p < 4; p++) begin : g_port
         wire [1:0] st = port_state[2*p+1:2*p];
         wire green_n = !(leds_live && used_reg[p] && green_on(st));
         wire amber_n = !(leds_live && amber_on(st, overcurrent_in_n[p], pwr_sw));
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               amber_led_removable_out[p] <= 1'b1;
               amber_led_removable_oe[p] <= 1'b0;
               green_led_port_active_out[p] <= 1'b1;
               green_led_port_active_oe[p] <= 1'b0;
               port_power_en_n[p] <= 1'b1;
            end else if (ce) begin
               amber_led_removable_out[p] <= amber_n;
               amber_led_removable_oe[p] <= (phase_reg == st_led);
               green_led_port_active_out[p] <= green_n;
               green_led_port_active_oe[p] <= (phase_reg == st_led);
               port_power_en_n[p] <= !(ctrl_reg[`CT_PWR_ON_LSB+p] && used_reg[p]);
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // AXI4-Lite slave
   // ----------------------------------------------------------------
   logic [`ADDR_W-1:0] awaddr_reg;
   logic aw_held;
   logic w_held;
   logic [7:0] wdata_reg;
   logic wstrb0_reg;
   wire aw_fire = s_axi_awvalid && s_axi_awready;
   wire w_fire = s_axi_wvalid && s_axi_wready;
   wire wr_go = aw_held && w_held && !s_axi_bvalid;
   wire wr_ctrl = awaddr_reg == `CTRL_OFF;
   wire wr_ok = wr_ctrl || awaddr_reg == `STATUS_OFF;
   wire ar_fire = s_axi_arvalid && s_axi_arready;
   wire rd_status = s_axi_araddr == `STATUS_OFF;
   wire rd_ctrl = s_axi_araddr == `CTRL_OFF;
   wire [31:0] status_word = {22'h0, phase_reg == st_led, ind_en_reg, used_reg,
                              removable_reg};
   wire [31:0] rd_word = rd_status ? status_word : rd_ctrl ? {24'h000000, ctrl_reg} : 32'h0;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         awaddr_reg <= '0;
         wdata_reg <= 8'h00;
         wstrb0_reg <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `RESP_OKAY;
         ctrl_reg <= `CTRL_RESET;
      end else if (ce) begin
         s_axi_awready <= !aw_held && !aw_fire && !s_axi_bvalid;
         s_axi_wready <= !w_held && !w_fire && !s_axi_bvalid;
         if (aw_fire) begin
            aw_held <= 1'b1;
            awaddr_reg <= s_axi_awaddr;
         end
         if (w_fire) begin
            w_held <= 1'b1;
            wdata_reg <= s_axi_wdata[7:0];
            wstrb0_reg <= s_axi_wstrb[0];
         end
         if (wr_go) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
            if (wr_ctrl && wstrb0_reg) begin
               ctrl_reg <= wdata_reg;
            end
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= `RESP_OKAY;
      end else if (ce) begin
         s_axi_arready <= !s_axi_rvalid && !ar_fire;
         if (ar_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= (rd_status || rd_ctrl) ? `RESP_OKAY : `RESP_SLVERR;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // Reset must be sampled inactive, else the edge that releases it looks like a capture
   wire loading = ce && aresetn && phase_reg == st_sample;

   property p_ind_low;
      loading && !indicator_strap_addr_bit3 |=> indicator_support;
   endproperty
   a_ind_low: assert property (p_ind_low) else $error("Indicator strap low not enabled");

   property p_ind_high;
      loading && indicator_strap_addr_bit3 |=> !indicator_support;
   endproperty
   a_ind_high: assert property (p_ind_high) else $error("Indicator strap high enabled");

   property p_addr3;
      ce && aresetn && smbus_host_attached
         |=> target_address_bit3 == $past(indicator_strap_addr_bit3);
   endproperty
   a_addr3: assert property (p_addr3) else $error("Address bit 3 mismatch");

   property p_removable;
      loading |=> port_removable == $past(amber_led_removable_in);
   endproperty
   a_removable: assert property (p_removable) else $error("Removable strap lost");

   property p_amber_drive;
      phase_reg == st_led && ce |=> amber_led_removable_oe == 4'hf;
   endproperty
   a_amber_drive: assert property (p_amber_drive) else $error("Amber pin not driven");

   property p_used;
      loading |=> port_used == $past(green_led_port_active_in);
   endproperty
   a_used: assert property (p_used) else $error("Port-used strap lost");

   property p_green_drive;
      phase_reg == st_led && ce |=> green_led_port_active_oe == 4'hf;
   endproperty
   a_green_drive: assert property (p_green_drive) else $error("Green pin not driven");

   property p_power;
      ce && phase_reg == st_led && !ctrl_reg[`CT_PWR_ON_LSB] |=> port_power_en_n[0];
   endproperty
   a_power: assert property (p_power) else $error("Port 0 powered without request");

   property p_green0;
      ce && leds_live && used_reg[0] && port_state[1:0] == ps_enabled
         |=> !green_led_port_active_out[0];
   endproperty
   a_green0: assert property (p_green0) else $error("Port 0 green not lit");

   property p_hold;
      phase_reg == st_led |=> $stable(port_removable) && $stable(port_used)
         && $stable(indicator_support);
   endproperty
   a_hold: assert property (p_hold) else $error("Straps changed after capture");

   property p_no_drive_early;
      phase_reg == st_sample |-> amber_led_removable_oe == 4'h0 && green_led_port_active_oe == 4'h0;
   endproperty
   a_no_drive_early: assert property (p_no_drive_early) else $error("Pin driven too early");

   c_ind_enabled: cover property (loading && !indicator_strap_addr_bit3);
   c_amber_lit: cover property (amber_led_removable_oe[0] && !amber_led_removable_out[0]);
   c_ctrl_write: cover property (wr_go && wr_ctrl);

endmodule : port_strap_and_indicator_leds

// ### board_straps_leds.sv
// Purpose: Board side of the shared strap and LED pins
// Assumes: Strap resistors hold a pin when the block does not drive it
// Notes: Over-current inputs idle high through the pull-up
`timescale 1ns/10ps
module board_straps_leds (
   input wire logic ind_strap,
   input wire logic [3:0] amber_strap,
   input wire logic [3:0] green_strap,
   input wire logic [3:0] amber_out,
   input wire logic [3:0] amber_oe,
   input wire logic [3:0] green_out,
   input wire logic [3:0] green_oe,
   input wire logic [3:0] oc_fault,
   output logic ind_pin,
   output logic [3:0] amber_pin,
   output logic [3:0] green_pin,
   output logic [3:0] overcurrent_in_n
);
   // ----------------------------------------
   // Pin levels
   // ----------------------------------------
   // Released pins fall back to the strap resistor level
   assign ind_pin = ind_strap;
   assign amber_pin = (amber_oe & amber_out) | (~amber_oe & amber_strap);
   assign green_pin = (green_oe & green_out) | (~green_oe & green_strap);
   assign overcurrent_in_n = ~oc_fault;
endmodule : board_straps_leds

// ### port_strap_and_indicator_leds_test.sv
// Purpose: Self-checking bench for the strap capture and LED block
// Assumes: ce high except for a two-cycle freeze near the end; registers reached over AXI4-Lite
// Notes: Two resets with different strap settings
`timescale 1ns/10ps
`include "port_strap_regs.svh"
module port_strap_and_indicator_leds_test;
   import port_strap_pkg::*;
   logic aclk, aresetn, ce, awvalid, wvalid, bready, arvalid, rready, smb, ind_s, ind_pin;
   logic awready, wready, bvalid, arready, rvalid, tab3, isup;
   logic [7:0] awaddr, araddr, pstate;
   logic [31:0] wdata, rdata, rd;
   logic [3:0] wstrb, am_s, gr_s, am_o, am_oe, gr_o, gr_oe, am_p, gr_p, ocf, oc_n;
   logic [3:0] pwr_n, prem, pused;
   logic [1:0] bresp, rresp, rsp;
   int num_errors = 0;
   int samples_checked = 0;
   // ----------------------------------------
   // Clock, watchdog, instances
   // ----------------------------------------
   initial begin
      aclk = 0;
      forever #20 aclk = ~aclk;
   end
   initial begin
      repeat (3000) @(posedge aclk);
      num_errors++;
      final_report();
   end
   port_strap_and_indicator_leds DUT (.aclk(aclk), .aresetn(aresetn), .ce(ce),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .indicator_strap_addr_bit3(ind_pin), .smbus_host_attached(smb),
      .target_address_bit3(tab3), .amber_led_removable_in(am_p),
      .amber_led_removable_out(am_o), .amber_led_removable_oe(am_oe),
      .green_led_port_active_in(gr_p), .green_led_port_active_out(gr_o),
      .green_led_port_active_oe(gr_oe), .overcurrent_in_n(oc_n), .port_state(pstate),
      .port_power_en_n(pwr_n), .port_removable(prem), .port_used(pused),
      .indicator_support(isup));
   board_straps_leds board (.ind_strap(ind_s), .amber_strap(am_s), .green_strap(gr_s),
      .amber_out(am_o), .amber_oe(am_oe), .green_out(gr_o), .green_oe(gr_oe),
      .oc_fault(ocf), .ind_pin(ind_pin), .amber_pin(am_p), .green_pin(gr_p),
      .overcurrent_in_n(oc_n));
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task check(input string name, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask : check
   task final_report();
      $display("Checks %0d errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : final_report
   task do_reset();
      aresetn <= 1'b0;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (3) @(posedge aclk);
   endtask : do_reset
   task axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      bit aw, w, b;
      aw = 0;
      w = 0;
      b = 0;
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hf;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!b) begin
         @(posedge aclk);
         if (bvalid && aw && w) begin
            b = 1;
            r = bresp;
            bready <= 1'b0;
         end
         if (awready && !aw) begin
            aw = 1;
            awvalid <= 1'b0;
         end
         if (wready && !w) begin
            w = 1;
            wvalid <= 1'b0;
         end
      end
      // Let the released strobes settle for one edge before the next call
      @(posedge aclk);
   endtask : axi_write
   task axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      bit ar, got;
      ar = 0;
      got = 0;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!got) begin
         @(posedge aclk);
         if (rvalid && ar) begin
            got = 1;
            d = rdata;
            r = rresp;
            rready <= 1'b0;
         end
         if (arready && !ar) begin
            ar = 1;
            arvalid <= 1'b0;
         end
      end
      @(posedge aclk);
   endtask : axi_read
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready, smb} = '0;
      {awaddr, araddr, wdata, wstrb} = '0;
      ce = 1'b1;
      ind_s = 1'b0;
      am_s = 4'b0101;
      gr_s = 4'b0111;
      ocf = 4'h0;
      pstate = 8'h00;
      do_reset();
      check("removable", 32'h5, prem);
      check("used", 32'h7, pused);
      check("ind_support", 32'h1, isup);
      check("amber_oe", 32'hf, am_oe);
      check("green_oe", 32'hf, gr_oe);
      @(posedge aclk);
      am_s <= 4'hf;
      gr_s <= 4'hf;
      axi_read(`STATUS_OFF, rd, rsp);
      check("status", 32'h375, rd);
      check("status_rd_resp", 32'h0, rsp);
      check("removable_held", 32'h5, prem);
      axi_read(`CTRL_OFF, rd, rsp);
      check("ctrl_reset", 32'h0, rd);
      axi_write(`STATUS_OFF, 32'h0, rsp);
      check("status_wr_resp", 32'h0, rsp);
      axi_write(8'h08, 32'hff, rsp);
      check("unmapped_wr", 32'h2, rsp);
      axi_read(8'h08, rd, rsp);
      check("unmapped_rd", 32'h2, rsp);
      check("unmapped_data", 32'h0, rd);
      pstate <= 8'hd3;
      ocf <= 4'b0110;
      axi_write(`CTRL_OFF, 32'hf1, rsp);
      repeat (3) @(posedge aclk);
      check("power_n", 32'h8, pwr_n);
      check("amber_sw", 32'hd, am_p);
      check("green", 32'he, gr_p);
      axi_write(`CTRL_OFF, 32'hf0, rsp);
      repeat (3) @(posedge aclk);
      check("amber_nosw", 32'hb, am_p);
      axi_read(`CTRL_OFF, rd, rsp);
      check("ctrl_rd", 32'hf0, rd);
      ind_s <= 1'b1;
      smb <= 1'b1;
      do_reset();
      check("ind_off", 32'h0, isup);
      check("addr_bit3", 32'h1, tab3);
      check("amber_dark", 32'hf, am_p);
      check("green_dark", 32'hf, gr_p);
      ce <= 1'b0;
      smb <= 1'b0;
      repeat (2) @(posedge aclk);
      check("addr_bit3_frozen", 32'h1, tab3);
      ce <= 1'b1;
      repeat (2) @(posedge aclk);
      check("addr_bit3_nohost", 32'h0, tab3);
      final_report();
   end
endmodule : port_strap_and_indicator_leds_test
